/* File: common/seq_pkg.sv */
// Shared constants and types for the major cycle sequencer.
package seq_pkg;

  // ****************************************************************
  // Widths and state codes
  // ****************************************************************
  localparam int PC_W = 16;
  localparam int CSA_W = 14;
  localparam int FLAG_W = 16;
  localparam int ST_W = 4;
  localparam int NUM_PSTATES = 8;
  localparam logic [3:0] ST_CONSOLE = 4'h8;
  localparam logic [3:0] ST_NULL = 4'h9;

  // ****************************************************************
  // Minor cycle indices
  // ****************************************************************
  localparam logic [3:0] MC_E0 = 4'h0;
  localparam logic [3:0] MC_E5 = 4'h5;
  localparam logic [3:0] MC_E6 = 4'h6;
  localparam logic [3:0] MC_E7 = 4'h7;
  localparam logic [3:0] MC_E8 = 4'h8;
  localparam logic [3:0] MC_E9 = 4'h9;

  // ****************************************************************
  // Register map and reset values
  // ****************************************************************
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_CONSOLE_ADDR = 8'h08;
  localparam logic [7:0] REG_MAJOR_COUNT = 8'h0c;
  localparam logic CTRL_RUN_RESET = 1'b1;
  localparam logic [CSA_W-1:0] CONSOLE_ADDR_RESET = 14'h0000;

  // Kind of initialization planned for the next major cycle.
  typedef enum logic [1:0] {INIT_NONE, INIT_OVERLAP, INIT_CONSOLE, INIT_APPEND} init_kind_t;

endpackage

/* File: common/seq_regs_if.sv */
// Control and status signals between the register slave and the sequencer core.
interface seq_regs_if;
  logic run;
  logic [13:0] console_addr;
  logic [3:0] cur_state;
  logic [3:0] minor;
  logic [1:0] init_kind;
  logic [15:0] major_count;

  modport regs (output run, output console_addr, input cur_state, input minor, input init_kind,
    input major_count);
  modport core (input run, input console_addr, output cur_state, output minor, output init_kind,
    output major_count);
endinterface

/* File: dv/seq_chk.sv */
// Port checker for the major cycle sequencer, bound to its top module.
module seq_chk
  import seq_pkg::*;
(
  input wire logic CLK,
  input wire logic RST,
  input wire logic [NUM_PSTATES-1:0] STATE_BUSY,
  input wire logic [PC_W-1:0] WORK_PC,
  input wire logic PC_SUPPRESS,
  input wire logic [FLAG_W-1:0] FLAG_REG,
  input wire logic [ST_W-1:0] XRF_RD_STATE,
  input wire logic [PC_W-1:0] XRF_PC_RDATA,
  input wire logic [FLAG_W-1:0] XRF_FLAG_RDATA,
  input wire logic XRF_PC_WE,
  input wire logic [PC_W-1:0] XRF_PC_WDATA,
  input wire logic XRF_FLAG_WE,
  input wire logic CS_RD,
  input wire logic [CSA_W-1:0] CS_ADDR,
  input wire logic EXEC_VALID,
  input wire logic [ST_W-1:0] EXEC_STATE,
  input wire logic [3:0] MINOR_CYCLE
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****
  // Clocking and properties
  // ****
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);

  // Each property except p_ext, which orders the appended cycles, ties a strobe or a loaded value to the minor cycle or the source that caused it.
  property p_cs_slot; CS_RD |-> (MINOR_CYCLE == MC_E7 || MINOR_CYCLE == MC_E9); endproperty
  a_cs_slot: assert property (p_cs_slot) else $error("control store read in wrong cycle");
  property p_rd_load; (MINOR_CYCLE == MC_E7 && CS_RD && XRF_RD_STATE < ST_CONSOLE)
    |-> {2'b00, CS_ADDR} == ($past(XRF_PC_RDATA) & 16'h3fff); endproperty
  a_rd_load: assert property (p_rd_load) else $error("sequencing address not from saved count");
  property p_flag_load; (MINOR_CYCLE == MC_E0 && $past(CS_RD) && $past(MINOR_CYCLE) == MC_E7)
    |-> FLAG_REG == ($past(XRF_RD_STATE) == ST_CONSOLE ? 16'h0000 : $past(XRF_FLAG_RDATA)); endproperty
  a_flag_load: assert property (p_flag_load) else $error("flag register not loaded at E0");
  property p_ext; MINOR_CYCLE == MC_E8 |=> MINOR_CYCLE == MC_E9 ##1 MINOR_CYCLE == MC_E0; endproperty
  a_ext: assert property (p_ext) else $error("appended cycles out of order");
  property p_app_addr; MINOR_CYCLE == MC_E9 |-> CS_RD
    && {2'b00, CS_ADDR} == (($past(PC_SUPPRESS) ? $past(XRF_PC_RDATA) : $past(WORK_PC)) & 16'h3fff); endproperty
  a_app_addr: assert property (p_app_addr) else $error("appended fetch address wrong");
  property p_busy; (MINOR_CYCLE == MC_E8 && !STATE_BUSY[EXEC_STATE[2:0]]) |-> ##2 !EXEC_VALID; endproperty
  a_busy: assert property (p_busy) else $error("cleared state resumed");
  property p_exec; EXEC_VALID |-> MINOR_CYCLE <= MC_E7; endproperty
  a_exec: assert property (p_exec) else $error("execution outside E0 to E7");
  property p_pc_we; XRF_PC_WE |-> MINOR_CYCLE == MC_E0 && !$past(PC_SUPPRESS); endproperty
  a_pc_we: assert property (p_pc_we) else $error("counter write-back misplaced");
  property p_pc_data; XRF_PC_WE |-> XRF_PC_WDATA == $past(WORK_PC); endproperty
  a_pc_data: assert property (p_pc_data) else $error("counter write-back data wrong");
  property p_flag_we; XRF_FLAG_WE |-> MINOR_CYCLE == 4'h1 && $past(MINOR_CYCLE) == MC_E0; endproperty
  a_flag_we: assert property (p_flag_we) else $error("flag write-back misplaced");

  // Main scenarios that the bench should reach.
  c_append: cover property (MINOR_CYCLE == MC_E9 ##1 EXEC_VALID);
  c_null: cover property (MINOR_CYCLE == MC_E9 ##1 !EXEC_VALID);
  c_flag_wb: cover property (XRF_FLAG_WE);
endmodule

bind multistate_major_cycle_sequencer seq_chk seq_chk_inst (.*);

/* File: dv/tb_top.sv */
// Self-checking bench for the major cycle sequencer.
module tb_top
  import seq_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic CLK, RST, HSEL, HWRITE, HREADY, HREADYOUT, HRESP, PC_SUPPRESS, FLAG_WE;
  logic XRF_PC_WE, XRF_FLAG_WE, CS_RD, EXEC_VALID;
  logic [31:0] HADDR, HWDATA, HRDATA, rd;
  logic [1:0] HTRANS;
  logic [2:0] HSIZE;
  logic [3:0] ALLOC_STATE, XRF_RD_STATE, XRF_WR_STATE, EXEC_STATE, MINOR_CYCLE;
  logic [7:0] STATE_BUSY;
  logic [15:0] WORK_PC, FLAG_WDATA, FLAG_REG, XRF_PC_RDATA, XRF_FLAG_RDATA, XRF_PC_WDATA, XRF_FLAG_WDATA;
  logic [13:0] CS_ADDR;
  int miscompares, cmp_count;

  // The single slave's ready is the bus ready.
  assign HREADY = HREADYOUT;

  multistate_major_cycle_sequencer multistate_major_cycle_sequencer_inst (.*);
  xrf_cs_model xrf_cs_model_inst (.*);

  // ****
  // Clock and common tasks
  // ****
  initial
  begin
    CLK = 1'b0;
    forever #5 CLK = ~CLK;
  end

  task give_verdict;
    $display("compares %0d, mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task stop_wait;
    miscompares++;
    $display("wait limit reached at %0t", $time);
    give_verdict;
  endtask

  // Waits on the falling edge until the minor cycle shows the value asked for.
  task wait_mc(input logic [3:0] v);
    int n;
    n = 0;
    do
    begin
      @(negedge CLK);
      n++;
    end
    while (MINOR_CYCLE !== v && n < 40);
    if (MINOR_CYCLE !== v)
      stop_wait;
  endtask

  task rdy_wait;
    int n;
    n = 0;
    do
    begin
      @(posedge CLK);
      n++;
    end
    while (HREADY !== 1'b1 && n < 20);
    if (HREADY !== 1'b1)
      stop_wait;
  endtask

  // One single word transfer; read data is taken at the edge that ends the data phase.
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge CLK);
    HSEL <= 1'b1;
    HTRANS <= 2'h2;
    HADDR <= {24'h0, a};
    HWRITE <= w;
    rdy_wait;
    HSEL <= 1'b0;
    HTRANS <= 2'h0;
    HWDATA <= d;
    rdy_wait;
    rd = HRDATA;
  endtask

  // Allocates a state after the next E0 and stops at E7, where initialization shows.
  task go(input logic [3:0] s);
    wait_mc(MC_E0);
    @(posedge CLK);
    ALLOC_STATE <= s;
    wait_mc(MC_E7);
  endtask

  // ****
  // Scenarios
  // ****
  task t_regs;
    repeat (10)
    begin
      @(negedge CLK);
      chk({XRF_PC_WE, XRF_FLAG_WE, CS_RD, EXEC_VALID}, 4'h0);
    end
    bus(1'b0, REG_STATUS, 32'h0);
    chk(rd[3:0], ST_NULL);
    chk(rd[9:8], INIT_NONE);
    chk({HREADYOUT, HRESP}, 2'h2);
    bus(1'b0, REG_CTRL, 32'h0);
    chk(rd[0], CTRL_RUN_RESET);
    bus(1'b0, REG_CONSOLE_ADDR, 32'h0);
    chk(rd, CONSOLE_ADDR_RESET);
    bus(1'b1, REG_CONSOLE_ADDR, 32'h1abc);
    bus(1'b0, REG_CONSOLE_ADDR, 32'h0);
    chk(rd, 32'h1abc);
    bus(1'b0, 8'h40, 32'h0);
    chk(rd, 32'h0);
    $display("register test done");
  endtask

  task t_overlap;
    go(4'h2);
    chk(CS_RD, 1'b1);
    chk(CS_ADDR, 14'h0102);
    wait_mc(MC_E0);
    chk(FLAG_REG, 16'h00a2);
    chk(EXEC_STATE, 4'h2);
    chk(EXEC_VALID, 1'b1);
    @(posedge CLK);
    WORK_PC <= 16'h8055;
    $display("overlap test done");
  endtask

  // Same state again: E8 and E9 are appended and the fetch comes from the working counter.
  task t_append;
    wait_mc(MC_E8);
    wait_mc(MC_E9);
    chk(CS_RD, 1'b1);
    chk(CS_ADDR, 14'h0055);
    wait_mc(MC_E0);
    chk(EXEC_STATE, 4'h2);
    chk(XRF_PC_WE, 1'b1);
    chk(XRF_PC_WDATA, 16'h8055);
    $display("append test done");
  endtask

  // Flags written during the cycle go back after the new state's flags are loaded.
  task t_switch;
    @(posedge CLK);
    FLAG_WE <= 1'b1;
    FLAG_WDATA <= 16'h0f0f;
    PC_SUPPRESS <= 1'b1;
    WORK_PC <= 16'h9999;
    ALLOC_STATE <= 4'h5;
    @(posedge CLK);
    FLAG_WE <= 1'b0;
    wait_mc(MC_E7);
    chk(CS_ADDR, 14'h0105);
    wait_mc(MC_E0);
    chk(FLAG_REG, 16'h00a5);
    chk(XRF_PC_WE, 1'b0);
    wait_mc(4'h2);
    chk(xrf_cs_model_inst.pc_mem[2], 16'h8055);
    chk(xrf_cs_model_inst.flag_mem[2], 16'h0f0f);
    $display("switch test done");
  endtask

  task t_console;
    @(posedge CLK);
    PC_SUPPRESS <= 1'b0;
    WORK_PC <= 16'h7777;
    ALLOC_STATE <= ST_CONSOLE;
    wait_mc(MC_E7);
    chk(CS_RD, 1'b1);
    chk(CS_ADDR, 14'h1abc);
    wait_mc(MC_E0);
    chk(FLAG_REG, 16'h0000);
    chk(EXEC_STATE, ST_CONSOLE);
    chk({XRF_PC_WE, XRF_WR_STATE}, 5'h15);
    chk(XRF_PC_WDATA, 16'h7777);
    wait_mc(4'h1);
    chk(XRF_FLAG_WE, 1'b0);
    $display("console test done");
  endtask

  // A state whose busy bit drops before E8 hands over to an idle major cycle; a suppressed counter refetches the saved one.
  task t_busy;
    @(posedge CLK);
    ALLOC_STATE <= 4'h3;
    wait_mc(MC_E0);
    chk(XRF_PC_WE, 1'b0);
    @(posedge CLK);
    STATE_BUSY <= 8'hf7;
    PC_SUPPRESS <= 1'b1;
    wait_mc(MC_E9);
    chk(CS_ADDR, 14'h0103);
    wait_mc(MC_E0);
    chk(EXEC_VALID, 1'b0);
    chk(XRF_PC_WE, 1'b0);
    bus(1'b0, REG_STATUS, 32'h0);
    chk(rd[3:0], ST_NULL);
    chk(xrf_cs_model_inst.pc_mem[3], 16'h4103);
    bus(1'b0, REG_MAJOR_COUNT, 32'h0);
    chk(rd, 32'h5);
    $display("busy test done");
  endtask

  // ****
  // Main sequence
  // ****
  initial
  begin
    RST = 1'b1;
    {HSEL, HWRITE, PC_SUPPRESS, FLAG_WE} = 4'h0;
    HADDR = 32'h0;
    HWDATA = 32'h0;
    HTRANS = 2'h0;
    HSIZE = 3'h2;
    ALLOC_STATE = ST_NULL;
    STATE_BUSY = 8'hff;
    WORK_PC = 16'h0;
    FLAG_WDATA = 16'h0;
    miscompares = 0;
    cmp_count = 0;
    repeat (16) @(posedge CLK);
    RST <= 1'b0;
    t_regs;
    t_overlap;
    t_append;
    t_switch;
    t_console;
    t_busy;
    give_verdict;
  end
endmodule

/* File: dv/xrf_cs_model.sv */
// Behavioural extended register file group one at the sequencer's far side.
module xrf_cs_model
(
  input wire logic CLK,
  input wire logic [3:0] XRF_RD_STATE,
  output logic [15:0] XRF_PC_RDATA,
  output logic [15:0] XRF_FLAG_RDATA,
  input wire logic [3:0] XRF_WR_STATE,
  input wire logic XRF_PC_WE,
  input wire logic [15:0] XRF_PC_WDATA,
  input wire logic XRF_FLAG_WE,
  input wire logic [15:0] XRF_FLAG_WDATA
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] pc_mem [8];
  logic [15:0] flag_mem [8];

  // Saved counters and flags start from a pattern keyed by state number.
  initial
  begin
    for (int i = 0; i < 8; i++)
    begin
      pc_mem[i] = 16'h4100 + 16'(i);
      flag_mem[i] = 16'h00a0 + 16'(i);
    end
  end

  // Reads are combinational; codes without a stored word give a scrambled value, not a stale one.
  assign XRF_PC_RDATA = XRF_RD_STATE < 4'h8 ? pc_mem[XRF_RD_STATE[2:0]] : ~pc_mem[0];
  assign XRF_FLAG_RDATA = XRF_RD_STATE < 4'h8 ? flag_mem[XRF_RD_STATE[2:0]] : ~flag_mem[0];

  // Write strobes land at the edge that ends their cycle.
  always @(posedge CLK)
  begin
    if (XRF_PC_WE && XRF_WR_STATE < 4'h8)
      pc_mem[XRF_WR_STATE[2:0]] <= XRF_PC_WDATA;
    if (XRF_FLAG_WE && XRF_WR_STATE < 4'h8)
      flag_mem[XRF_WR_STATE[2:0]] <= XRF_FLAG_WDATA;
  end
endmodule

/* File: rtl/minor_cycle_counter.sv */
// Minor cycle counter that runs E0 to E7, optionally extended through E9.
module minor_cycle_counter
  import seq_pkg::*;
#(
  parameter int LAST_BASE = 7,
  parameter int LAST_EXT = 9
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic extend,
  output logic [3:0] idx,
  output logic wrap
);

  // ****************************************************************
  // Parameter check
  // ****************************************************************
  if (LAST_EXT <= LAST_BASE || LAST_EXT > 15)
  begin
    $error("minor_cycle_counter: extended last cycle must follow the base last cycle");
  end

  // The last minor cycle of the major cycle ends it.
  assign wrap = (idx == 4'(LAST_EXT)) || (idx == 4'(LAST_BASE) && !extend);

  // Advance one minor cycle per clock, back to E0 after the last one.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      idx <= MC_E0;
    else if (wrap)
      idx <= MC_E0;
    else
      idx <= idx + 4'h1;
  end

endmodule

/* File: rtl/multistate_major_cycle_sequencer.sv */
// Major cycle sequencer for a multi-state micro-programmed processor.
module multistate_major_cycle_sequencer
  import seq_pkg::*;
(
  input wire logic CLK,
  input wire logic RST,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic HREADYOUT,
  output logic HRESP,
  output logic [31:0] HRDATA,
  input wire logic [ST_W-1:0] ALLOC_STATE,
  input wire logic [NUM_PSTATES-1:0] STATE_BUSY,
  input wire logic [PC_W-1:0] WORK_PC,
  input wire logic PC_SUPPRESS,
  input wire logic FLAG_WE,
  input wire logic [FLAG_W-1:0] FLAG_WDATA,
  output logic [FLAG_W-1:0] FLAG_REG,
  output logic [ST_W-1:0] XRF_RD_STATE,
  input wire logic [PC_W-1:0] XRF_PC_RDATA,
  input wire logic [FLAG_W-1:0] XRF_FLAG_RDATA,
  output logic [ST_W-1:0] XRF_WR_STATE,
  output logic XRF_PC_WE,
  output logic [PC_W-1:0] XRF_PC_WDATA,
  output logic XRF_FLAG_WE,
  output logic [FLAG_W-1:0] XRF_FLAG_WDATA,
  output logic CS_RD,
  output logic [CSA_W-1:0] CS_ADDR,
  output logic EXEC_VALID,
  output logic [ST_W-1:0] EXEC_STATE,
  output logic [3:0] MINOR_CYCLE
);

  // ****************************************************************
  // Internal signals
  // ****************************************************************
  seq_regs_if regs_bus ();

  logic [3:0] idx;
  logic wrap;
  init_kind_t kind;
  logic [ST_W-1:0] cur_state;
  logic [ST_W-1:0] sel_state;
  logic [ST_W-1:0] alloc_eff;
  logic [CSA_W-1:0] seq_addr;
  logic [FLAG_W-1:0] flag_buf;
  logic flag_dirty;
  logic flag_pend;
  logic busy_lost;
  logic cur_is_proc;
  logic [15:0] major_count;

  // ****************************************************************
  // Register slave and minor cycle timing
  // ****************************************************************
  seq_ahb_regs u_regs (
    .clk(CLK),
    .rst(RST),
    .hsel(HSEL),
    .haddr(HADDR),
    .htrans(HTRANS),
    .hwrite(HWRITE),
    .hsize(HSIZE),
    .hwdata(HWDATA),
    .hready(HREADY),
    .hreadyout(HREADYOUT),
    .hresp(HRESP),
    .hrdata(HRDATA),
    .regs(regs_bus.regs)
  );

  // The appended cycles E8 and E9 exist only for a repeated state.
  minor_cycle_counter #(
    .LAST_BASE(7),
    .LAST_EXT(9)
  ) u_minor (
    .clk(CLK),
    .rst(RST),
    .extend(kind == INIT_APPEND),
    .idx(idx),
    .wrap(wrap)
  );

  // Status reported to software.
  assign regs_bus.cur_state = cur_state;
  assign regs_bus.minor = idx;
  assign regs_bus.init_kind = kind;
  assign regs_bus.major_count = major_count;

  // ****************************************************************
  // Allocation and initialization planning
  // ****************************************************************

  // Stopped sequencing or an unknown code is treated as an idle allocation.
  always_comb
  begin
    if (!regs_bus.run || ALLOC_STATE > ST_NULL)
      alloc_eff = ST_NULL;
    else
      alloc_eff = ALLOC_STATE;
  end

  assign cur_is_proc = cur_state < ST_CONSOLE;

  // At E5 the allocator's choice is taken and the kind of initialization fixed.
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      sel_state <= ST_NULL;
      kind <= INIT_NONE;
    end
    else if (idx == MC_E5)
    begin
      sel_state <= alloc_eff;
      if (alloc_eff == cur_state && cur_is_proc)
        kind <= INIT_APPEND;
      else if (alloc_eff < ST_CONSOLE)
        kind <= INIT_OVERLAP;
      else if (alloc_eff == ST_CONSOLE)
        kind <= INIT_CONSOLE;
      else
        kind <= INIT_NONE;
    end
    else if (wrap)
      kind <= INIT_NONE;
  end

  // The register file read port addresses the state being initialized.
  assign XRF_RD_STATE = sel_state;

  // ****************************************************************
  // Sequencing address register
  // ****************************************************************

  // R0 at E6 or the appended E8 loads the address for the first fetch.
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
      seq_addr <= {CSA_W{1'b0}};
    else if (idx == MC_E6 && kind == INIT_OVERLAP)
      seq_addr <= XRF_PC_RDATA[CSA_W-1:0];
    else if (idx == MC_E6 && kind == INIT_CONSOLE)
      seq_addr <= regs_bus.console_addr;
    else if (idx == MC_E8 && kind == INIT_APPEND)
    begin
      if (PC_SUPPRESS)
        seq_addr <= XRF_PC_RDATA[CSA_W-1:0];
      else
        seq_addr <= WORK_PC[CSA_W-1:0];
    end
  end

  assign CS_ADDR = seq_addr;

  // Control store read strobe stands in R1 (E7) or in the appended E9.
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
      CS_RD <= 1'b0;
    else if (idx == MC_E6 && (kind == INIT_OVERLAP || kind == INIT_CONSOLE))
      CS_RD <= 1'b1;
    else if (idx == MC_E8 && kind == INIT_APPEND)
      CS_RD <= 1'b1;
    else
      CS_RD <= 1'b0;
  end

  // ****************************************************************
  // Current state and busy tracking
  // ****************************************************************

  // The busy flip-flop of a repeated state is checked during E8.
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
      busy_lost <= 1'b0;
    else if (idx == MC_E8 && kind == INIT_APPEND)
      busy_lost <= !STATE_BUSY[cur_state[2:0]];
    else if (wrap)
      busy_lost <= 1'b0;
  end

  // A new major cycle starts at the wrap to E0.
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
      cur_state <= ST_NULL;
    else if (wrap)
    begin
      if (kind == INIT_APPEND && busy_lost)
        cur_state <= ST_NULL;
      else
        cur_state <= sel_state;
    end
  end

  // Count of major cycles given to a non-idle state.
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
      major_count <= 16'h0000;
    else if (wrap && cur_state != ST_NULL)
      major_count <= major_count + 16'h0001;
  end

  // Execution slots E0 to E7 belong to the current non-idle state.
  assign EXEC_VALID = idx <= MC_E7 && cur_state != ST_NULL;
  assign EXEC_STATE = cur_state;
  assign MINOR_CYCLE = idx;

  // ****************************************************************
  // Common flag register and its buffer
  // ****************************************************************

  // The common flags are clocked at the start of E0 from the initializing processing state, or cleared for the console.
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
      FLAG_REG <= {FLAG_W{1'b0}};
    else if (idx == MC_E7 && kind == INIT_OVERLAP)
      FLAG_REG <= XRF_FLAG_RDATA;
    else if (idx == MC_E7 && kind == INIT_CONSOLE)
      FLAG_REG <= {FLAG_W{1'b0}};
    else if (FLAG_WE)
      FLAG_REG <= FLAG_WDATA;
  end

  // The outgoing state's final flags are kept while the new ones take over.
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
      flag_buf <= {FLAG_W{1'b0}};
    else if (wrap)
      flag_buf <= FLAG_WE ? FLAG_WDATA : FLAG_REG;
  end

  // A flag write during a major cycle is remembered; the clear at the wrap wins over a write in the same cycle.
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
      flag_dirty <= 1'b0;
    else if (FLAG_WE && !wrap)
      flag_dirty <= 1'b1;
    else if (wrap)
      flag_dirty <= 1'b0;
  end

  // ****************************************************************
  // Housekeeping write-back
  // ****************************************************************

  // W0 stands during E0 and writes the working PC of an outgoing processing state unless suppressed.
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      XRF_PC_WE <= 1'b0;
      XRF_PC_WDATA <= {PC_W{1'b0}};
      XRF_WR_STATE <= ST_NULL;
    end
    else if (wrap)
    begin
      XRF_PC_WE <= cur_is_proc && !PC_SUPPRESS;
      XRF_PC_WDATA <= WORK_PC;
      XRF_WR_STATE <= cur_state;
    end
    else
      XRF_PC_WE <= 1'b0;
  end

  // The W1 flag write-back is planned at the wrap and carried out in E1.
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
      flag_pend <= 1'b0;
    else if (wrap)
      flag_pend <= cur_is_proc && (flag_dirty || FLAG_WE);
    else
      flag_pend <= 1'b0;
  end

  // W1 stands during E1 and writes the buffered flags.
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      XRF_FLAG_WE <= 1'b0;
      XRF_FLAG_WDATA <= {FLAG_W{1'b0}};
    end
    else
    begin
      XRF_FLAG_WE <= flag_pend && idx == MC_E0;
      XRF_FLAG_WDATA <= flag_buf;
    end
  end

endmodule

/* File: rtl/seq_ahb_regs.sv */
// AHB-Lite slave holding the sequencer control and status registers.
module seq_ahb_regs
  import seq_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  seq_regs_if.regs regs
);

  logic wr_pend;
  logic [7:0] wr_addr;
  logic take;

  // Zero wait state slave that always answers OKAY.
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign take = hsel && hready && htrans[1];

  // Address phase capture for writes; the data follow in the next cycle.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
    end
    else
    begin
      wr_pend <= take && hwrite && hsize == 3'h2;
      wr_addr <= haddr[7:0];
    end
  end

  // Writable registers; unmapped writes are dropped.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      regs.run <= CTRL_RUN_RESET;
      regs.console_addr <= CONSOLE_ADDR_RESET;
    end
    else if (wr_pend)
    begin
      if (wr_addr == REG_CTRL)
        regs.run <= hwdata[0];
      if (wr_addr == REG_CONSOLE_ADDR)
        regs.console_addr <= hwdata[13:0];
    end
  end

  // Read data registered at the address phase so it stands in the data phase.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      hrdata <= 32'h0000_0000;
    else if (take && !hwrite)
    begin
      case (haddr[7:0])
        REG_CTRL: hrdata <= {31'h0000_0000, regs.run};
        REG_STATUS: hrdata <= {22'h00_0000, regs.init_kind, regs.minor, regs.cur_state};
        REG_CONSOLE_ADDR: hrdata <= {18'h0_0000, regs.console_addr};
        REG_MAJOR_COUNT: hrdata <= {16'h0000, regs.major_count};
        default: hrdata <= 32'h0000_0000;
      endcase
    end
  end

endmodule
